// *** logic/adc_reset_abort_control_defines.vh ***
`ifndef ADC_RESET_ABORT_CONTROL_DEFINES_VH
`define ADC_RESET_ABORT_CONTROL_DEFINES_VH

// Clock
`define ARC_CLK_PERIOD_NS   50

// Pin and conversion timing in ns
`define ARC_RST_LOW_MIN_NS  25
`define ARC_ABORT_MAX_NS    50
`define ARC_RESUME_MAX_NS   20
`define ARC_FIRST_SAMP_NS   20
`define ARC_CONV_NS         650

// Widths and reset values
`define ARC_DATA_W          16
`define ARC_CNT_W           4
`define ARC_STATE_W         3
`define ARC_DATA_RST        16'h0000
`define ARC_CNT_ZERO        4'h0
`define ARC_CNT_ONE         4'h1

`endif

// *** logic/adc_reset_abort_control.v ***
`timescale 1ns/1ps
`include "adc_reset_abort_control_defines.vh"

// Overview of operation
// - Reset pin acts alone, whatever chip select shows.
// - A running conversion is aborted within 50 ns of reset.
// - Reset clears the result latch to zero.
// - Normal operation resumes at the first clock edge after reset release, within one 50 ns period.
// - First sampling period begins at the second clock edge after reset release.
// - Later sampling begins at the later of busy fall and select fall.
// - Start falling with select low during conversion resets the converter.
// - Select falling during conversion resets the converter.
// - Internal resets clear themselves without host action.
// - Power-on reset initialises the block without the reset pin.
// - Busy rises after start falls and falls when conversion ends.
// - Each conversion takes 650 ns on the internal clock.

module adc_reset_abort_control (
   // Clock and power-on reset
   input  wire                    i_clk_sys,
   input  wire                    i_nrst,
   // Host control pins
   input  wire                    i_reset_n,
   input  wire                    i_cs_n,
   input  wire                    i_conversion_start_n,
   // Code from the analog SAR array
   input  wire [`ARC_DATA_W-1:0]  i_sar_code,
   // Status and result
   output wire                    o_busy,
   output wire                    o_sampling,
   output wire                    o_in_reset,
   output wire                    o_abort,
   output wire                    o_data_valid,
   output wire [`ARC_DATA_W-1:0]  o_data
);

   // Cycle counts from times
   localparam integer P_NS      = `ARC_CLK_PERIOD_NS;
   localparam integer RST_RAW   = (`ARC_RST_LOW_MIN_NS + P_NS - 1) / P_NS;
   localparam integer RST_CYC   = (RST_RAW < 1) ? 1 : RST_RAW;
   localparam integer ABORT_RAW = `ARC_ABORT_MAX_NS / P_NS;
   localparam integer ABORT_CYC = (ABORT_RAW < 1) ? 1 : ABORT_RAW;
   localparam integer RES_RAW   = `ARC_RESUME_MAX_NS / P_NS;
   localparam integer RES_CYC   = (RES_RAW < 1) ? 1 : RES_RAW;
   localparam integer SMP_RAW   = (`ARC_FIRST_SAMP_NS + P_NS - 1) / P_NS;
   localparam integer SMP_LEAST = (SMP_RAW < 1) ? 1 : SMP_RAW;
   localparam integer SMP_CYC   = (SMP_LEAST > RES_CYC) ? SMP_LEAST
                                                        : RES_CYC;
   localparam integer CONV_RAW  = `ARC_CONV_NS / P_NS;
   localparam integer CONV_CYC  = (CONV_RAW < 1) ? 1 : CONV_RAW;

   // Counter loads, cut to the counter width on purpose
   localparam integer RST_M1    = RST_CYC - 1;
   localparam integer SMP_M1    = SMP_CYC - 1;
   localparam integer CONV_M1   = CONV_CYC - 1;

   localparam [`ARC_CNT_W-1:0] RST_LOAD  = RST_M1[`ARC_CNT_W-1:0];
   localparam [`ARC_CNT_W-1:0] SMP_LOAD  = SMP_M1[`ARC_CNT_W-1:0];
   localparam [`ARC_CNT_W-1:0] CONV_LOAD = CONV_M1[`ARC_CNT_W-1:0];

   // Positions of the watched pins in the edge detector
   localparam integer PIN_SEL   = 0;
   localparam integer PIN_START = 1;
   localparam integer PIN_NUM   = 2;

   // States
   localparam [`ARC_STATE_W-1:0] ST_RESET   = 3'h0;
   localparam [`ARC_STATE_W-1:0] ST_RECOVER = 3'h1;
   localparam [`ARC_STATE_W-1:0] ST_SAMPLE  = 3'h2;
   localparam [`ARC_STATE_W-1:0] ST_CONVERT = 3'h3;
   localparam [`ARC_STATE_W-1:0] ST_WAIT    = 3'h4;

   // Falling edge of an active-low pin
   function fell;
      input prev;
      input cur;
      begin
         fell = prev & ~cur;
      end
   endfunction

   // Counter has run out
   function cnt_done;
      input [`ARC_CNT_W-1:0] cnt;
      begin
         cnt_done = (cnt == `ARC_CNT_ZERO);
      end
   endfunction

   // Counter one step down
   function [`ARC_CNT_W-1:0] cnt_next;
      input [`ARC_CNT_W-1:0] cnt;
      begin
         cnt_next = cnt - `ARC_CNT_ONE;
      end
   endfunction

   reg [`ARC_STATE_W-1:0] state_q;
   reg [`ARC_STATE_W-1:0] state_d;
   reg [`ARC_CNT_W-1:0]   cnt_q;
   reg [`ARC_CNT_W-1:0]   cnt_d;
   reg                    busy_q;
   reg                    busy_d;
   reg                    samp_q;
   reg                    samp_d;
   reg                    abort_q;
   reg                    abort_d;
   reg                    valid_q;
   reg                    valid_d;
   reg [`ARC_DATA_W-1:0]  data_q;
   reg [`ARC_DATA_W-1:0]  data_d;
   wire [PIN_NUM-1:0]     pin_now;
   wire [PIN_NUM-1:0]     pin_fall;

   assign pin_now[PIN_SEL]   = i_cs_n;
   assign pin_now[PIN_START] = i_conversion_start_n;

   // Falling-edge detectors; history starts at the pins' idle high level
   genvar g;
   generate
      for (g = 0; g < PIN_NUM; g = g + 1) begin : g_pin_edge
         reg prev_q;
         always @(posedge i_clk_sys) begin
            if (!i_nrst) begin
               prev_q <= 1'b1;
            end else begin
               prev_q <= pin_now[g];
            end
         end
         assign pin_fall[g] = fell(prev_q, pin_now[g]);
      end
   endgenerate

   wire cs_fall   = pin_fall[PIN_SEL];
   wire cst_fall  = pin_fall[PIN_START];
   wire start_req = cst_fall && !i_cs_n;
   wire conv_run  = (state_q == ST_CONVERT);
   wire pin_rst   = ~i_reset_n;
   wire int_rst   = conv_run && (cs_fall || start_req);

   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      busy_d  = busy_q;
      samp_d  = samp_q;
      abort_d = 1'b0;
      valid_d = 1'b0;
      data_d  = data_q;
      if (pin_rst) begin
         // Pin reset ignores chip select
         state_d = ST_RESET;
         cnt_d   = `ARC_CNT_ZERO;
         busy_d  = 1'b0;
         samp_d  = 1'b0;
         abort_d = (state_q == ST_CONVERT);
         data_d  = `ARC_DATA_RST;
      end else if (int_rst) begin
         // Self-clearing reset timed from the abort edge
         state_d = ST_RESET;
         cnt_d   = RST_LOAD;
         busy_d  = 1'b0;
         samp_d  = 1'b0;
         abort_d = 1'b1;
         data_d  = `ARC_DATA_RST;
      end else begin
         case (state_q)
            ST_RESET: begin
               data_d = `ARC_DATA_RST;
               if (cnt_done(cnt_q)) begin
                  state_d = ST_RECOVER;
                  cnt_d   = SMP_LOAD;
               end else begin
                  cnt_d = cnt_next(cnt_q);
               end
            end
            ST_RECOVER: begin
               if (cnt_done(cnt_q)) begin
                  state_d = ST_SAMPLE;
                  samp_d  = 1'b1;
               end else begin
                  cnt_d = cnt_next(cnt_q);
               end
            end
            ST_SAMPLE: begin
               if (start_req) begin
                  state_d = ST_CONVERT;
                  cnt_d   = CONV_LOAD;
                  busy_d  = 1'b1;
                  samp_d  = 1'b0;
               end
            end
            ST_CONVERT: begin
               if (cnt_done(cnt_q)) begin
                  busy_d  = 1'b0;
                  valid_d = 1'b1;
                  data_d  = i_sar_code;
                  if (!i_cs_n) begin
                     state_d = ST_SAMPLE;
                     samp_d  = 1'b1;
                  end else begin
                     state_d = ST_WAIT;
                  end
               end else begin
                  cnt_d = cnt_next(cnt_q);
               end
            end
            ST_WAIT: begin
               if (cs_fall) begin
                  state_d = ST_SAMPLE;
                  samp_d  = 1'b1;
               end
            end
            default: begin
               state_d = ST_RESET;
               cnt_d   = `ARC_CNT_ZERO;
               busy_d  = 1'b0;
               samp_d  = 1'b0;
            end
         endcase
      end
   end

   // State and cycle counter; power-on acts like a released pin reset
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_q <= ST_RESET;
         cnt_q   <= `ARC_CNT_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Status flags
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         busy_q  <= 1'b0;
         samp_q  <= 1'b0;
         abort_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         busy_q  <= busy_d;
         samp_q  <= samp_d;
         abort_q <= abort_d;
         valid_q <= valid_d;
      end
   end

   // Result latch
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         data_q <= `ARC_DATA_RST;
      end else begin
         data_q <= data_d;
      end
   end

   assign o_busy       = busy_q;
   assign o_sampling   = samp_q;
   assign o_in_reset   = (state_q == ST_RESET);
   assign o_abort      = abort_q;
   assign o_data_valid = valid_q;
   assign o_data       = data_q;

endmodule // adc_reset_abort_control

// *** testbench/adc_reset_abort_control_checker.sv ***
`timescale 1ns/1ps
module adc_reset_abort_control_checker (
   // Clock, reset and host pins
   input wire logic        i_clk_sys,
   input wire logic        i_nrst,
   input wire logic        i_reset_n,
   input wire logic        i_cs_n,
   input wire logic        i_conversion_start_n,
   input wire logic [15:0] i_sar_code,
   // Status and result
   input wire logic        o_busy,
   input wire logic        o_sampling,
   input wire logic        o_in_reset,
   input wire logic        o_abort,
   input wire logic        o_data_valid,
   input wire logic [15:0] o_data
);
   logic [3:0] busy_cnt_q;
   always @(posedge i_clk_sys)
      busy_cnt_q <= (!i_nrst || !o_busy) ? 4'h0 : busy_cnt_q + 4'h1;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   a_start_busy: assert property ($fell(i_conversion_start_n)
      && !i_cs_n && o_sampling && i_reset_n |=> o_busy) else $error("no busy");
   a_conv_len: assert property (o_data_valid |-> busy_cnt_q == 4'hd
      && o_data == $past(i_sar_code)) else $error("bad conversion");
   a_cs_abort: assert property (o_busy && $fell(i_cs_n) |=> o_abort
      && !o_busy && o_data == 16'h0000) else $error("no select abort");
   a_start_abort: assert property (o_busy && !i_cs_n
      && $fell(i_conversion_start_n) |=> o_abort && o_in_reset)
      else $error("no start abort");
   a_pin_reset: assert property (!i_reset_n |=> o_in_reset
      && !o_busy && o_data == 16'h0000) else $error("pin reset");
   a_resume: assert property ($rose(i_reset_n) |=> !o_in_reset
      ##1 o_sampling) else $error("no resume");
   a_self_clear: assert property (o_abort && i_reset_n |=>
      !o_in_reset && !o_data_valid ##1 o_sampling) else $error("stuck");
   a_next_sample: assert property (o_data_valid |->
      o_sampling == !$past(i_cs_n)) else $error("bad resample");
   cover property (o_data_valid);
   cover property (o_abort && i_reset_n);
   cover property ($rose(i_reset_n));
endmodule // adc_reset_abort_control_checker
bind adc_reset_abort_control adc_reset_abort_control_checker chk (.*);

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
module host_model (
   input  wire        i_clk_sys,
   output reg         o_reset_n,
   output reg         o_cs_n,
   output reg         o_start_n,
   output reg  [15:0] o_code
);
   initial {o_reset_n, o_cs_n, o_start_n, o_code} = {3'h7, 16'h0000};
   task set_code(input logic [15:0] d);
      o_code = d;
   endtask
   // Pins held a full 50 ns period
   task pins(input logic r, c, s);
      @(negedge i_clk_sys);
      {o_reset_n, o_cs_n, o_start_n} = {r, c, s};
   endtask
endmodule // host_model

// *** testbench/tb_adc_reset_abort_control.sv ***
`timescale 1ns/1ps
module tb_adc_reset_abort_control;
   logic        i_clk_sys = 1'b0;
   logic        i_nrst = 1'b0;
   wire         i_reset_n, i_cs_n, i_conversion_start_n;
   wire  [15:0] i_sar_code, o_data;
   wire         o_busy, o_sampling, o_in_reset, o_abort, o_data_valid;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cyc = 0;
   always #25 i_clk_sys = ~i_clk_sys;
   host_model host (.i_clk_sys(i_clk_sys), .o_reset_n(i_reset_n),
      .o_cs_n(i_cs_n), .o_start_n(i_conversion_start_n), .o_code(i_sar_code));
   adc_reset_abort_control dut (.*);
   task check(input string n, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 500) begin
         miscompares++;
         finish_test;
      end
   end
   task nxt(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task conv(input logic [15:0] d);
      host.set_code(d);
      host.pins(1'b1, 1'b0, 1'b1);
      host.pins(1'b1, 1'b0, 1'b0);
      host.pins(1'b1, 1'b0, 1'b1);
      check("busy", o_busy, 1'b1);
   endtask
   task t_convert(input logic [15:0] d);
      conv(d);
      nxt(13);
      check("valid", o_data_valid, 1'b1);
      check("busy", o_busy, 1'b0);
      check("data", o_data, d);
      check("sampling", o_sampling, 1'b1);
      $display("convert done");
   endtask
   task t_pin_reset;
      conv(16'h1234);
      host.pins(1'b0, 1'b1, 1'b1);
      nxt(1);
      check("in reset", o_in_reset, 1'b1);
      check("busy", o_busy, 1'b0);
      check("data", o_data, 16'h0000);
      check("abort", o_abort, 1'b1);
      host.pins(1'b1, 1'b1, 1'b1);
      nxt(1);
      check("in reset", o_in_reset, 1'b0);
      nxt(1);
      check("sampling", o_sampling, 1'b1);
      $display("pin reset done");
   endtask
   task t_cs_abort;
      conv(16'h8001);
      host.pins(1'b1, 1'b1, 1'b1);
      host.pins(1'b1, 1'b0, 1'b1);
      nxt(1);
      check("abort", o_abort, 1'b1);
      check("busy", o_busy, 1'b0);
      check("data", o_data, 16'h0000);
      nxt(2);
      check("sampling", o_sampling, 1'b1);
      check("valid", o_data_valid, 1'b0);
      $display("select abort done");
   endtask
   task t_start_abort;
      conv(16'h4321);
      host.pins(1'b1, 1'b0, 1'b0);
      nxt(1);
      check("abort", o_abort, 1'b1);
      check("busy", o_busy, 1'b0);
      check("data", o_data, 16'h0000);
      host.pins(1'b1, 1'b0, 1'b1);
      nxt(1);
      check("sampling", o_sampling, 1'b1);
      $display("start abort done");
   endtask
   task t_wait;
      conv(16'hfffe);
      host.pins(1'b1, 1'b1, 1'b1);
      nxt(12);
      check("valid", o_data_valid, 1'b1);
      check("idle", o_sampling, 1'b0);
      host.pins(1'b1, 1'b0, 1'b1);
      nxt(1);
      check("sampling", o_sampling, 1'b1);
      $display("select wait done");
   endtask
   initial begin
      nxt(5);
      i_nrst = 1'b1;
      nxt(2);
      check("sampling", o_sampling, 1'b1);
      for (int i = 1; i < 4; i++)
         t_convert(16'h1111 << i);
      t_pin_reset();
      t_convert(16'h7fff);
      t_cs_abort();
      t_start_abort();
      t_wait();
      finish_test();
   end
endmodule // tb_adc_reset_abort_control
